// ### lmpc_checker.sv
// Function
// - linear address is segment shifted four plus offset
// - offset above 64K faults with vector 13
// - paged 20-bit linear address, 256 pages
// - task switch reloads page directory base
// - compatibility code runs at privilege three
// - privileged instructions fault 13 above level zero
// - protected-only instructions fault 6 outside protected
// - protected mode: port and IF ops sensitive
// - compat mode: INTn, IF, flags, return sensitive
// - breakpoint, overflow, bounds never privilege sensitive
// - compat port access checked against bitmap
// - bitmap pointer read at task segment 66h
// - one bit per port, set bit faults
// - wide accesses need all covered bits clear
// - bits beyond segment limit count as set
// - compat faults go to level-zero handler
// - handler entry clears live flag, image keeps it
// - level zero I/O privilege traps every INTn in compat mode
// - flag set by return or switch, cleared by entry
// - pushed flags always show flag clear
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module lmpc_checker
    import lmpc_pkg::*;
(
    input wire logic clk, // core clock, 125 MHz
    input wire logic resetn, // asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire lmpc_req_t chk_req, // instruction check request
    output logic chk_ready, // checker idle, request taken
    output lmpc_rsp_t chk_rsp, // check result pulse
    output lmpc_walk_t page_walk, // page table walk request
    output logic mem_rd_req, // task segment read request
    output logic [31:0] mem_addr, // task segment read address
    input wire logic [15:0] mem_rdata, // task segment read word
    input wire logic mem_ack, // read data valid
    input wire lmpc_irq_t irq_take, // interrupt taken by core
    input wire lmpc_interrupt_return_insn_t interrupt_return_insn_exec, // interrupt return executed
    input wire lmpc_tsw_t task_switch, // task switch completed
    output lmpc_entry_t handler_entry, // level-zero handler entry
    output logic compat_mode_flag // live mode flag
);
    function automatic logic [31:0] seg_linear(input logic [15:0] seg, input logic [31:0] ofs);
        seg_linear = ({16'h0000, seg} << SEG_SHIFT) + ofs;
    endfunction

    function automatic logic [3:0] io_last(input logic [1:0] size);
        io_last = (size == 2'h0) ? 4'h0 : (size == 2'h1) ? 4'h1 : 4'h3;
    endfunction

    lmpc_state_t state, next_state;
    lmpc_req_t req_q;
    logic prot_enable, paging_en;
    logic [1:0] io_privilege_level, cpl_reg;
    logic [31:0] tss_base, tss_limit, page_directory_base_reg;
    logic [7:0] last_vector;
    logic [15:0] fault_count;

    // privilege and mode decode
    wire real_mode = !prot_enable;
    wire in_compat = prot_enable & compat_mode_flag;
    wire [1:0] current_privilege_level = real_mode ? PL_KERNEL :
        in_compat ? PL_COMPAT : cpl_reg;
    wire io_privilege_level_fault = current_privilege_level > io_privilege_level;
    wire take = (state == S_IDLE) & chk_req.valid;
    wire lmpc_op_t op = chk_req.op;

    wire ofs_fault = (real_mode | in_compat) & (op == OP_MEM)
        & (chk_req.offset > OFS_LIMIT);
    wire priv_fault = (op == OP_PRIV) & (current_privilege_level != PL_KERNEL);
    wire prot_only_fault = (op == OP_PROT_ONLY) & (real_mode | in_compat);
    wire prot_sens = prot_enable & !in_compat
        & ((op == OP_IO) | (op == OP_IF_SET_CLR));
    // exempt software interrupts are deliberately absent from both sets
    wire compat_sens = in_compat & ((op == OP_IF_SET_CLR) | (op == OP_FLAGS_PUSH_INSN)
        | (op == OP_FLAGS_POP_INSN) | (op == OP_INTERRUPT_RETURN_INSN) | (op == OP_INTN));
    wire sens_fault = (prot_sens | compat_sens) & io_privilege_level_fault;
    wire needs_map = in_compat & (op == OP_IO);
    wire imm_fault = ofs_fault | priv_fault | prot_only_fault | sens_fault;
    wire [7:0] imm_vector = prot_only_fault ? VEC_UD : VEC_GP;
    wire [31:0] lin_addr = seg_linear(chk_req.seg, chk_req.offset);

    // bitmap location and limit check, from the held request
    wire [16:0] last_port = {1'b0, req_q.port} + {13'h0000, io_last(req_q.io_size)};
    wire [12:0] first_byte = req_q.port[15:MAP_BYTE_SHIFT];
    wire [13:0] last_byte = last_port[16:MAP_BYTE_SHIFT];
    wire [16:0] map_last_ofs = {1'b0, mem_rdata} + {3'h0, last_byte};
    wire map_beyond = ({16'h0000, mem_rdata} > tss_limit)
        | ({15'h0000, map_last_ofs} > tss_limit);
    wire [31:0] map_addr = tss_base + {16'h0000, mem_rdata} + {19'h00000, first_byte};
    // a 16-bit read covers any span that starts in the first byte
    wire [15:0] map_mask = ((16'h0001 << ({1'b0, io_last(req_q.io_size)} + 5'h01))
        - 16'h0001) << req_q.port[2:0];
    wire map_fault = |(mem_rdata & map_mask);

    wire imm_done = take & !needs_map;
    wire ptr_fault = (state == S_PTR_RD) & mem_ack & map_beyond;
    wire map_done = (state == S_MAP_RD) & mem_ack;
    wire fault_now = (imm_done & imm_fault) | ptr_fault | (map_done & map_fault);
    wire done_now = imm_done | ptr_fault | map_done;
    wire [7:0] vector_now = imm_done ? imm_vector : VEC_GP;
    wire [31:0] fault_flags = imm_done ? chk_req.flags_word : req_q.flags_word;
    wire fault_from_compat = (state != S_IDLE) | in_compat;
    wire [31:0] vm_set = 32'h1 << VM_BIT;

    always_comb begin
        next_state = state;
        unique case (state)
            S_IDLE: if (take && needs_map) next_state = S_PTR_RD;
            S_PTR_RD: if (mem_ack) next_state = map_beyond ? S_IDLE : S_MAP_RD;
            S_MAP_RD: if (mem_ack) next_state = S_IDLE;
        endcase
    end

    // mode flag: a set event wins over a clear event in the same cycle
    wire mode_set = prot_enable & ((interrupt_return_insn_exec.valid & interrupt_return_insn_exec.is32 & interrupt_return_insn_exec.image_vm
        & !in_compat & (cpl_reg == PL_KERNEL))
        | (task_switch.valid & task_switch.new_vm));
    wire mode_clear = (in_compat & irq_take.valid)
        | (fault_now & fault_from_compat);
    wire next_mode = mode_set ? 1'b1 : mode_clear ? 1'b0 : compat_mode_flag;

    // core faults outrank an interrupt offered in the same cycle
    wire entry_fault = fault_now;
    wire [31:0] entry_src = entry_fault ? fault_flags : irq_take.flags_word;
    wire entry_vm = entry_fault ? fault_from_compat : in_compat;
    wire [31:0] next_image = entry_vm ? (entry_src | vm_set) : (entry_src & ~vm_set);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= S_IDLE;
            req_q <= '0;
            chk_ready <= 1'b0;
            chk_rsp <= '0;
            mem_rd_req <= 1'b0;
            mem_addr <= RST_WORD;
        end else begin
            state <= next_state;
            chk_ready <= (next_state == S_IDLE);
            if (take) req_q <= chk_req;
            chk_rsp.valid <= done_now;
            chk_rsp.fault <= fault_now;
            chk_rsp.vector <= fault_now ? vector_now : 8'h00;
            if (take) chk_rsp.lin_addr <= lin_addr;
            chk_rsp.data <= (imm_done && op == OP_FLAGS_PUSH_INSN) ? (chk_req.flags_word & ~vm_set)
                : RST_WORD;
            if (take && needs_map) begin
                mem_rd_req <= 1'b1;
                mem_addr <= tss_base + TSS_MAP_PTR_OFS;
            end else if (state == S_PTR_RD && mem_ack && !map_beyond) begin
                mem_rd_req <= 1'b1;
                mem_addr <= map_addr;
            end else if (mem_ack) begin
                mem_rd_req <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            page_walk <= '0;
            handler_entry <= '0;
            compat_mode_flag <= 1'b0;
        end else begin
            page_walk.valid <= imm_done & !imm_fault & (op == OP_MEM) & paging_en & in_compat;
            page_walk.pdbr <= page_directory_base_reg;
            page_walk.page_idx <= lin_addr[PAGE_IDX_LSB +: PAGE_IDX_W];
            handler_entry.valid <= entry_fault | irq_take.valid;
            handler_entry.vector <= entry_fault ? vector_now : irq_take.vector;
            handler_entry.flags_image <= next_image;
            compat_mode_flag <= next_mode;
        end
    end

    // register bus: one wait state, write commits on the ready edge
    wire acc = psel & penable;
    wire commit = acc & pready & pwrite;
    wire hit_ctrl = paddr == REG_CTRL;
    wire hit_status = paddr == REG_STATUS;
    wire hit_base = paddr == REG_TSS_BASE;
    wire hit_limit = paddr == REG_TSS_LIMIT;
    wire hit_pdbr = paddr == REG_PDBR;
    wire mapped = hit_ctrl | hit_status | hit_base | hit_limit | hit_pdbr;
    wire [31:0] ctrl_word = ({31'h0, prot_enable} << CTRL_PE)
        | ({31'h0, paging_en} << CTRL_PG)
        | ({30'h0, io_privilege_level} << CTRL_IO_PRIVILEGE_LEVEL_LSB)
        | ({30'h0, cpl_reg} << CTRL_CPL_LSB);
    wire [31:0] status_word = ({31'h0, compat_mode_flag} << ST_VM)
        | ({24'h0, last_vector} << ST_VEC_LSB)
        | ({16'h0, fault_count} << ST_CNT_LSB);
    wire [31:0] rd_data = hit_ctrl ? ctrl_word : hit_status ? status_word :
        hit_base ? tss_base : hit_limit ? tss_limit : hit_pdbr ? page_directory_base_reg :
        RST_WORD;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= RST_WORD;
        end else begin
            pready <= acc & !pready;
            pslverr <= acc & !pready & !mapped;
            prdata <= (acc && !pready && !pwrite) ? rd_data : RST_WORD;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prot_enable <= 1'b0;
            paging_en <= 1'b0;
            io_privilege_level <= PL_KERNEL;
            cpl_reg <= PL_KERNEL;
            tss_base <= RST_WORD;
            tss_limit <= RST_WORD;
        end else if (commit && hit_ctrl) begin
            prot_enable <= pwdata[CTRL_PE];
            paging_en <= pwdata[CTRL_PG];
            io_privilege_level <= pwdata[CTRL_IO_PRIVILEGE_LEVEL_LSB +: 2];
            cpl_reg <= pwdata[CTRL_CPL_LSB +: 2];
        end else if (commit && hit_base) begin
            tss_base <= pwdata;
        end else if (commit && hit_limit) begin
            tss_limit <= pwdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            page_directory_base_reg <= RST_WORD;
            last_vector <= 8'h00;
            fault_count <= 16'h0000;
        end else begin
            if (task_switch.valid) page_directory_base_reg <= task_switch.new_pdbr;
            else if (commit && hit_pdbr) page_directory_base_reg <= pwdata;
            if (fault_now) begin
                last_vector <= vector_now;
                fault_count <= fault_count + 16'h0001;
            end
        end
    end

    property p_seg_shift;
        @(posedge clk) disable iff (!resetn)
        take && (chk_req.op == OP_MEM) |=> chk_rsp.valid
            && (chk_rsp.lin_addr == (({16'h0000, $past(chk_req.seg)} << SEG_SHIFT)
            + $past(chk_req.offset)));
    endproperty
    a_seg_shift: assert property (p_seg_shift) else $error("linear address wrong");

    property p_ofs_limit;
        @(posedge clk) disable iff (!resetn)
        take && in_compat && (chk_req.op == OP_MEM) && (chk_req.offset > OFS_LIMIT)
            |=> chk_rsp.fault && (chk_rsp.vector == VEC_GP);
    endproperty
    a_ofs_limit: assert property (p_ofs_limit) else $error("offset limit missed");

    property p_priv;
        @(posedge clk) disable iff (!resetn)
        take && (chk_req.op == OP_PRIV) && in_compat ##1 chk_rsp.valid
            |-> chk_rsp.fault && (chk_rsp.vector == VEC_GP) && handler_entry.valid;
    endproperty
    a_priv: assert property (p_priv) else $error("privileged op not faulted");

    property p_prot_only;
        @(posedge clk) disable iff (!resetn)
        take && (chk_req.op == OP_PROT_ONLY) && real_mode
            |=> chk_rsp.fault && (chk_rsp.vector == VEC_UD);
    endproperty
    a_prot_only: assert property (p_prot_only) else $error("vector 6 missed");

    property p_exempt;
        @(posedge clk) disable iff (!resetn)
        take && (chk_req.op == OP_INT_EXEMPT) |=> chk_rsp.valid && !chk_rsp.fault;
    endproperty
    a_exempt: assert property (p_exempt) else $error("exempt op faulted");

    property p_flags_push_insn_vm;
        @(posedge clk) disable iff (!resetn)
        chk_rsp.valid |-> !chk_rsp.data[VM_BIT];
    endproperty
    a_flags_push_insn_vm: assert property (p_flags_push_insn_vm) else $error("pushed flag visible");

    property p_entry_clears;
        @(posedge clk) disable iff (!resetn)
        in_compat && irq_take.valid && !mode_set
            |=> handler_entry.valid && handler_entry.flags_image[VM_BIT] && !compat_mode_flag;
    endproperty
    a_entry_clears: assert property (p_entry_clears) else $error("entry kept flag");

    property p_map_bound;
        @(posedge clk) disable iff (!resetn)
        (state == S_PTR_RD) && mem_ack && ({16'h0000, mem_rdata} > tss_limit)
            |=> chk_rsp.fault && (state == S_IDLE) && !mem_rd_req;
    endproperty
    a_map_bound: assert property (p_map_bound) else $error("pointer beyond limit");

    property p_walk_pdbr;
        @(posedge clk) disable iff (!resetn)
        task_switch.valid |=> page_directory_base_reg == $past(task_switch.new_pdbr);
    endproperty
    a_walk_pdbr: assert property (p_walk_pdbr) else $error("base not reloaded");

    c_map_ok: cover property (@(posedge clk) disable iff (!resetn)
        map_done && !map_fault);
    c_map_fault: cover property (@(posedge clk) disable iff (!resetn)
        map_done && map_fault);
    c_intn_trap: cover property (@(posedge clk) disable iff (!resetn)
        take && in_compat && (chk_req.op == OP_INTN) && (io_privilege_level == PL_KERNEL));
    c_enter: cover property (@(posedge clk) disable iff (!resetn)
        !compat_mode_flag ##1 compat_mode_flag);
endmodule
`default_nettype wire

// ### lmpc_pkg.sv
package lmpc_pkg;
    // exception vectors
    localparam logic [7:0] VEC_GP = 8'h0d;
    localparam logic [7:0] VEC_UD = 8'h06;
    // compatibility-mode address formation
    localparam int SEG_SHIFT = 4;
    localparam logic [31:0] OFS_LIMIT = 32'h0000_ffff;
    localparam int PAGE_IDX_LSB = 12;
    localparam int PAGE_IDX_W = 8;
    // task state segment layout
    localparam logic [31:0] TSS_MAP_PTR_OFS = 32'h0000_0066;
    localparam int MAP_BYTE_SHIFT = 3;
    // flags word layout
    localparam int VM_BIT = 17;
    localparam logic [1:0] PL_KERNEL = 2'h0;
    localparam logic [1:0] PL_COMPAT = 2'h3;
    // register map (byte addresses)
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_TSS_BASE = 12'h008;
    localparam logic [11:0] REG_TSS_LIMIT = 12'h00c;
    localparam logic [11:0] REG_PDBR = 12'h010;
    // control fields
    localparam int CTRL_PE = 0;
    localparam int CTRL_PG = 1;
    localparam int CTRL_IO_PRIVILEGE_LEVEL_LSB = 2;
    localparam int CTRL_CPL_LSB = 4;
    // status fields
    localparam int ST_VM = 0;
    localparam int ST_VEC_LSB = 8;
    localparam int ST_CNT_LSB = 16;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    typedef enum logic [3:0] {
        OP_MEM, OP_PRIV, OP_PROT_ONLY, OP_IO, OP_IF_SET_CLR, OP_FLAGS_PUSH_INSN,
        OP_FLAGS_POP_INSN, OP_INTERRUPT_RETURN_INSN, OP_INTN, OP_INT_EXEMPT, OP_OTHER
    } lmpc_op_t;

    typedef enum logic [1:0] {S_IDLE, S_PTR_RD, S_MAP_RD} lmpc_state_t;

    typedef struct packed {
        logic valid;
        lmpc_op_t op;
        logic [15:0] seg;
        logic [31:0] offset;
        logic [15:0] port;
        logic [1:0] io_size;
        logic [31:0] flags_word;
    } lmpc_req_t;

    typedef struct packed {
        logic valid;
        logic fault;
        logic [7:0] vector;
        logic [31:0] lin_addr;
        logic [31:0] data;
    } lmpc_rsp_t;

    typedef struct packed {
        logic valid;
        logic [31:0] pdbr;
        logic [7:0] page_idx;
    } lmpc_walk_t;

    typedef struct packed {
        logic valid;
        logic [7:0] vector;
        logic [31:0] flags_word;
    } lmpc_irq_t;

    typedef struct packed {
        logic valid;
        logic is32;
        logic image_vm;
    } lmpc_interrupt_return_insn_t;

    typedef struct packed {
        logic valid;
        logic new_vm;
        logic [31:0] new_pdbr;
    } lmpc_tsw_t;

    typedef struct packed {
        logic valid;
        logic [7:0] vector;
        logic [31:0] flags_image;
    } lmpc_entry_t;
endpackage

// ### tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import lmpc_pkg::*;
;
    localparam logic [31:0] TSS_BASE = 32'h0000_1000;
    localparam logic [31:0] TSS_LIM = 32'h0000_0200;
    localparam logic [31:0] FL = 32'h0002_0202;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, chk_ready, mem_rd_req;
    logic mem_ack = 1'b0, ack_d = 1'b0, compat_mode_flag, rd_err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, mem_addr, rd_data, lin, addr_q[$];
    logic [15:0] mem_rdata = 16'h0, cur_ptr = 16'h0, map_word;
    lmpc_req_t chk_req = '0;
    lmpc_rsp_t chk_rsp, rsp_s;
    lmpc_walk_t page_walk, walk_s;
    lmpc_irq_t irq_take = '0;
    lmpc_interrupt_return_insn_t interrupt_return_insn_exec = '0;
    lmpc_tsw_t task_switch = '0;
    lmpc_entry_t handler_entry, ent_s;
    int failures = 0, n_tests = 0, n_ent = 0, n_walk = 0, n0, k;

    lmpc_checker dut_u (
        .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chk_req(chk_req), .chk_ready(chk_ready), .chk_rsp(chk_rsp), .page_walk(page_walk),
        .mem_rd_req(mem_rd_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
        .irq_take(irq_take), .interrupt_return_insn_exec(interrupt_return_insn_exec), .task_switch(task_switch),
        .handler_entry(handler_entry), .compat_mode_flag(compat_mode_flag)
    );

    initial begin
        forever #4 clk = ~clk;
    end

    // eight mapped bytes, then all ones as the terminator
    assign map_word = (mem_addr - TSS_BASE - cur_ptr < 32'h8) ? 16'h0410 : 16'hffff;

    // ack every third cycle at most so a changed read address is seen first
    always @(posedge clk) begin
        ack_d <= mem_ack;
        if (mem_rd_req === 1'b1 && !mem_ack && !ack_d) begin
            mem_ack <= 1'b1;
            mem_rdata <= (mem_addr == TSS_BASE + TSS_MAP_PTR_OFS) ? cur_ptr : map_word;
            addr_q.push_back(mem_addr);
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end
        if (handler_entry.valid === 1'b1) begin
            ent_s <= handler_entry;
            n_ent <= n_ent + 1;
        end
        if (page_walk.valid === 1'b1) begin
            walk_s <= page_walk;
            n_walk <= n_walk + 1;
        end
    end

    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic tmo(input string what);
        failures++;
        $display("unexpected timeout on %s", what);
        finish_test;
    endtask

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) tmo("pready");
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input lmpc_op_t op, input logic [15:0] seg, input logic [31:0] ofs,
                       input logic [15:0] port, input logic [1:0] sz);
        int i;
        addr_q.delete();
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (chk_ready === 1'b1) break;
        end
        if (i == 20) tmo("chk_ready");
        chk_req <= '{1'b1, op, seg, ofs, port, sz, FL};
        @(posedge clk);
        chk_req.valid <= 1'b0;
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            if (chk_rsp.valid === 1'b1) break;
        end
        if (i == 40) tmo("chk_rsp");
        rsp_s = chk_rsp;
    endtask

    task automatic enter(input logic w32, input logic exp);
        @(posedge clk);
        interrupt_return_insn_exec <= '{1'b1, w32, 1'b1};
        @(posedge clk);
        interrupt_return_insn_exec <= '0;
        repeat (2) @(posedge clk);
        cmp("mode after return", {31'h0, exp}, {31'h0, compat_mode_flag});
        apb(1'b0, REG_STATUS, 32'h0);
        cmp("status mode", {31'h0, exp}, {31'h0, rd_data[ST_VM]});
    endtask

    task automatic run(input lmpc_op_t op, input logic [5:0] ctrl, input logic vm,
                       input logic [7:0] vec, input int nrd, input logic [15:0] port,
                       input logic [1:0] sz, input logic [15:0] ptr);
        int n1;
        logic [31:0] ea;
        apb(1'b1, REG_CTRL, {26'h0, ctrl});
        if (vm) enter(1'b1, 1'b1);
        cur_ptr = ptr;
        n1 = n_ent;
        chk(op, 16'h0, 32'h0, port, sz);
        repeat (3) @(posedge clk);
        ea = TSS_BASE + {16'h0, ptr} + {19'h0, port[15:MAP_BYTE_SHIFT]};
        cmp("vector", {24'h0, vec}, {24'h0, rsp_s.vector});
        cmp("fault", {31'h0, vec != 8'h0}, {31'h0, rsp_s.fault});
        cmp("map reads", nrd, addr_q.size());
        if (nrd > 0) cmp("pointer addr", TSS_BASE + TSS_MAP_PTR_OFS, addr_q[0]);
        if (nrd > 1) cmp("map addr", ea, addr_q[1]);
        ea = (op == OP_FLAGS_PUSH_INSN && vec == 8'h0) ? (FL & ~(32'h1 << VM_BIT)) : 32'h0;
        cmp("pushed flags", ea, rsp_s.data);
        cmp("entries", n1 + (vec != 8'h0), n_ent);
        cmp("live mode", {31'h0, vm && vec == 8'h0}, {31'h0, compat_mode_flag});
        if (vec != 8'h0) begin
            cmp("entry vector", {24'h0, vec}, {24'h0, ent_s.vector});
            cmp("saved mode", {31'h0, vm}, {31'h0, ent_s.flags_image[VM_BIT]});
        end
    endtask

    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        for (k = 0; k < 5; k++) begin
            apb(1'b0, 12'(4 * k), 32'h0);
            cmp("reset value", RST_WORD, rd_data);
        end
        apb(1'b0, 12'h014, 32'h0);
        cmp("unmapped error", 32'h1, {31'h0, rd_err});
        cmp("unmapped data", 32'h0, rd_data);
        apb(1'b1, REG_TSS_BASE, TSS_BASE);
        apb(1'b1, REG_TSS_LIMIT, TSS_LIM);
        apb(1'b0, REG_TSS_LIMIT, 32'h0);
        cmp("segment limit", TSS_LIM, rd_data);
        apb(1'b1, REG_CTRL, 32'h0000_0031);
        enter(1'b1, 1'b0);
        apb(1'b1, REG_CTRL, 32'h0000_0001);
        enter(1'b0, 1'b0);
        $display("test registers and mode entry done");
        // pointers stay far below the DFFFh ceiling
        run(OP_PRIV, 6'h01, 1'h1, VEC_GP, 0, 16'h0, 2'h0, 16'h100);
        run(OP_INTN, 6'h0d, 1'h1, 8'h0, 0, 16'h0, 2'h0, 16'h100);
        run(OP_INTN, 6'h01, 1'h1, VEC_GP, 0, 16'h0, 2'h0, 16'h100);
        run(OP_FLAGS_PUSH_INSN, 6'h0d, 1'h1, 8'h0, 0, 16'h0, 2'h0, 16'h100);
        run(OP_INT_EXEMPT, 6'h01, 1'h1, 8'h0, 0, 16'h0, 2'h0, 16'h100);
        run(OP_FLAGS_POP_INSN, 6'h01, 1'h1, VEC_GP, 0, 16'h0, 2'h0, 16'h100);
        run(OP_INTERRUPT_RETURN_INSN, 6'h0d, 1'h1, 8'h0, 0, 16'h0, 2'h0, 16'h100);
        run(OP_IF_SET_CLR, 6'h01, 1'h1, VEC_GP, 0, 16'h0, 2'h0, 16'h100);
        run(OP_PROT_ONLY, 6'h01, 1'h1, VEC_UD, 0, 16'h0, 2'h0, 16'h100);
        run(OP_PROT_ONLY, 6'h00, 1'h0, VEC_UD, 0, 16'h0, 2'h0, 16'h100);
        run(OP_IO, 6'h31, 1'h0, VEC_GP, 0, 16'h23, 2'h0, 16'h100);
        run(OP_IF_SET_CLR, 6'h31, 1'h0, VEC_GP, 0, 16'h0, 2'h0, 16'h100);
        run(OP_IO, 6'h0d, 1'h1, 8'h0, 2, 16'h23, 2'h0, 16'h100);
        run(OP_IO, 6'h0d, 1'h1, VEC_GP, 2, 16'h24, 2'h0, 16'h100);
        run(OP_IO, 6'h01, 1'h1, 8'h0, 2, 16'h27, 2'h1, 16'h100);
        run(OP_IO, 6'h01, 1'h1, VEC_GP, 2, 16'h27, 2'h2, 16'h100);
        run(OP_IO, 6'h01, 1'h1, VEC_GP, 1, 16'h23, 2'h0, 16'h300);
        run(OP_IO, 6'h01, 1'h1, VEC_GP, 1, 16'h100, 2'h0, 16'h1f0);
        $display("test instruction checks done");
        apb(1'b1, REG_CTRL, 32'h0000_0003);
        @(posedge clk);
        task_switch <= '{1'b1, 1'b1, 32'h0012_3000};
        @(posedge clk);
        task_switch <= '0;
        apb(1'b0, REG_PDBR, 32'h0);
        cmp("page base", 32'h0012_3000, rd_data);
        cmp("mode after switch", 32'h1, {31'h0, compat_mode_flag});
        n0 = n_walk;
        lin = ({16'h0, 16'h1234} << SEG_SHIFT) + 32'h0000_ffff;
        chk(OP_MEM, 16'h1234, 32'h0000_ffff, 16'h0, 2'h0);
        cmp("linear address", lin, rsp_s.lin_addr);
        cmp("offset at limit", 32'h0, {31'h0, rsp_s.fault});
        repeat (2) @(posedge clk);
        cmp("walks", n0 + 1, n_walk);
        cmp("walk base", 32'h0012_3000, walk_s.pdbr);
        cmp("walk page", {24'h0, lin[19:12]}, {24'h0, walk_s.page_idx});
        chk(OP_MEM, 16'h1234, 32'h0001_0000, 16'h0, 2'h0);
        cmp("offset over limit", {24'h0, VEC_GP}, {24'h0, rsp_s.vector});
        $display("test addressing done");
        apb(1'b1, REG_CTRL, 32'h0000_0001);
        enter(1'b1, 1'b1);
        n0 = n_ent;
        @(posedge clk);
        irq_take <= '{1'b1, 8'h20, FL};
        @(posedge clk);
        irq_take <= '0;
        repeat (3) @(posedge clk);
        cmp("irq entries", n0 + 1, n_ent);
        cmp("irq vector", 32'h20, {24'h0, ent_s.vector});
        cmp("irq saved mode", 32'h1, {31'h0, ent_s.flags_image[VM_BIT]});
        cmp("irq live mode", 32'h0, {31'h0, compat_mode_flag});
        $display("test interrupt entry done");
        finish_test;
    end
endmodule
`default_nettype wire
